// ### esc_pkg.sv
// Purpose: shared constants, types and helpers of the DMA event channel selector
// Assumes: one 32-bit APB slave; event inputs are pulses on pclk
// Notes:   every offset, field position and value after reset lives here
package esc_pkg;

  localparam int ESC_CHANNELS  = 16;
  localparam int ESC_CODE_W    = 6;
  localparam int ESC_FIELD_STR = 8;
  localparam int ESC_FIELDS    = 4;
  localparam int ESC_TABLE_W   = 16;
  localparam int ESC_CHAIN_LO  = 8;

  localparam logic [31:0] ESC_ADDR_MAP_0_3   = 32'h01A0FF00;
  localparam logic [31:0] ESC_ADDR_MAP_4_7   = 32'h01A0FF04;
  localparam logic [31:0] ESC_ADDR_HOLE      = 32'h01A0FF08;
  localparam logic [31:0] ESC_ADDR_MAP_12_15 = 32'h01A0FF0C;

  localparam logic [31:0] ESC_RST_MAP_0_3   = 32'h03020100;
  localparam logic [31:0] ESC_RST_MAP_4_7   = 32'h07060504;
  localparam logic [31:0] ESC_RST_MAP_12_15 = 32'h0F0E0D0C;
  localparam logic [31:0] ESC_RESV_MASK     = 32'hC0C0C0C0;

  localparam logic [5:0] ESC_CODE_HOST_DOORBELL = 6'h00;
  localparam logic [5:0] ESC_CODE_TIMER0        = 6'h01;
  localparam logic [5:0] ESC_CODE_TIMER1        = 6'h02;
  localparam logic [5:0] ESC_CODE_MEMIF         = 6'h03;
  localparam logic [5:0] ESC_CODE_GPIO4         = 6'h04;
  localparam logic [5:0] ESC_CODE_GPIO5         = 6'h05;
  localparam logic [5:0] ESC_CODE_GPIO6         = 6'h06;
  localparam logic [5:0] ESC_CODE_GPIO7         = 6'h07;
  localparam logic [5:0] ESC_CODE_RESV_8        = 6'h08;
  localparam logic [5:0] ESC_CODE_GPIO2         = 6'h0A;
  localparam logic [5:0] ESC_CODE_SER0_TX       = 6'h0C;
  localparam logic [5:0] ESC_CODE_SER0_RX       = 6'h0D;
  localparam logic [5:0] ESC_CODE_SER1_TX       = 6'h0E;
  localparam logic [5:0] ESC_CODE_SER1_RX       = 6'h0F;
  localparam logic [5:0] ESC_CODE_TABLE_END     = 6'h10;

  typedef enum logic [1:0] {
    ESC_REG_0_3,
    ESC_REG_4_7,
    ESC_REG_12_15,
    ESC_REG_NONE
  } esc_reg_e;

  typedef struct packed {
    logic host_doorbell_event;
    logic timer0_event;
    logic timer1_event;
    logic memory_interface_event;
    logic gpio_pin4_event;
    logic gpio_pin5_event;
    logic gpio_pin6_event;
    logic gpio_pin7_event;
    logic gpio_pin2_event;
    logic serial0_transmit_event;
    logic serial0_receive_event;
    logic serial1_transmit_event;
    logic serial1_receive_event;
  } esc_events_s;

  typedef struct packed {
    logic chain_complete_11;
    logic chain_complete_10;
    logic chain_complete_9;
    logic chain_complete_8;
  } esc_chain_s;

  function automatic esc_reg_e esc_decode(input logic [31:0] addr);
    esc_reg_e r;
    case (addr)
      ESC_ADDR_MAP_0_3:   r = ESC_REG_0_3;
      ESC_ADDR_MAP_4_7:   r = ESC_REG_4_7;
      ESC_ADDR_MAP_12_15: r = ESC_REG_12_15;
      default:            r = ESC_REG_NONE;
    endcase
    return r;
  endfunction

  // reserved codes keep their table slot at zero
  function automatic logic [15:0] esc_event_table(input esc_events_s ev);
    logic [15:0] v;
    v = 16'h0000;
    v[ESC_CODE_HOST_DOORBELL[3:0]] = ev.host_doorbell_event;
    v[ESC_CODE_TIMER0[3:0]]        = ev.timer0_event;
    v[ESC_CODE_TIMER1[3:0]]        = ev.timer1_event;
    v[ESC_CODE_MEMIF[3:0]]         = ev.memory_interface_event;
    v[ESC_CODE_GPIO4[3:0]]         = ev.gpio_pin4_event;
    v[ESC_CODE_GPIO5[3:0]]         = ev.gpio_pin5_event;
    v[ESC_CODE_GPIO6[3:0]]         = ev.gpio_pin6_event;
    v[ESC_CODE_GPIO7[3:0]]         = ev.gpio_pin7_event;
    v[ESC_CODE_GPIO2[3:0]]         = ev.gpio_pin2_event;
    v[ESC_CODE_SER0_TX[3:0]]       = ev.serial0_transmit_event;
    v[ESC_CODE_SER0_RX[3:0]]       = ev.serial0_receive_event;
    v[ESC_CODE_SER1_TX[3:0]]       = ev.serial1_transmit_event;
    v[ESC_CODE_SER1_RX[3:0]]       = ev.serial1_receive_event;
    return v;
  endfunction

endpackage

// ### esc_event_mux.sv
// Purpose: picks one event from the code table for one channel
// Assumes: table built by esc_pkg::esc_event_table
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/1ps
module esc_event_mux (
  // selection
  input  wire logic [5:0]  code,
  input  wire logic [15:0] table_vec,
  // result
  output logic             hit
);

  // codes at or above the table end never fire
  always_comb begin
    if (code < esc_pkg::ESC_CODE_TABLE_END) begin
      hit = table_vec[code[3:0]];
    end else begin
      hit = 1'b0;
    end
  end

endmodule

// ### esc_sel_reg.sv
// Purpose: one selector register of four 6-bit channel code fields
// Assumes: one byte strobe per field
// Notes:   reserved bits are not stored and read as zero
`timescale 1ns/1ps
module esc_sel_reg #(
  parameter logic [31:0] RST_VAL = 32'h00000000
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // write port
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_strb,
  input  wire logic [31:0] wr_data,
  // contents
  output logic [31:0]      q
);

  typedef struct packed {
    logic [3:0][5:0] code;
  } esc_sel_s;

  esc_sel_s s_reg;
  esc_sel_s s_next;

  always_comb begin
    s_next = s_reg;
    for (int i = 0; i < esc_pkg::ESC_FIELDS; i++) begin
      if (wr_en && wr_strb[i]) begin
        s_next.code[i] = wr_data[i*esc_pkg::ESC_FIELD_STR +: esc_pkg::ESC_CODE_W];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < esc_pkg::ESC_FIELDS; i++) begin
        s_reg.code[i] <= RST_VAL[i*esc_pkg::ESC_FIELD_STR +: esc_pkg::ESC_CODE_W];
      end
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    q = 32'h00000000;
    for (int i = 0; i < esc_pkg::ESC_FIELDS; i++) begin
      q[i*esc_pkg::ESC_FIELD_STR +: esc_pkg::ESC_CODE_W] = s_reg.code[i];
    end
  end

endmodule

// ### esc_selector.sv
// Purpose: routes peripheral events and chain completions onto sixteen DMA channel triggers
// Assumes: APB4 slave with byte strobes, zero wait states; events are pulses on pclk
// Notes:   triggers lag the event by one pclk cycle
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module esc_selector (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // event sources
  input  wire esc_pkg::esc_events_s events,
  input  wire esc_pkg::esc_chain_s  chain,
  // dma channel triggers
  output logic [15:0]             channel_trigger
);

  typedef struct packed {
    logic [31:0] prdata;
    logic        slverr;
    logic [15:0] trig;
    logic [2:0]  wr_seen;
  } esc_state_s;

  esc_state_s s_reg;
  esc_state_s s_next;

  logic [31:0]           q_0_3;
  logic [31:0]           q_4_7;
  logic [31:0]           q_12_15;
  logic [15:0]           table_vec;
  logic [15:0]           route;
  logic [2:0]            wr_en;
  logic                  setup;
  logic                  access;
  esc_pkg::esc_reg_e     idx;
  logic [3:0][5:0]       code_lo;
  logic [3:0][5:0]       code_mid;
  logic [3:0][5:0]       code_hi;

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign idx    = esc_pkg::esc_decode(paddr);

  // no wait states: every access ends in its first access cycle
  assign pready = 1'b1;

  // write lands on the access edge only; unmapped writes are dropped
  assign wr_en[0] = access && pwrite && (idx == esc_pkg::ESC_REG_0_3);
  assign wr_en[1] = access && pwrite && (idx == esc_pkg::ESC_REG_4_7);
  assign wr_en[2] = access && pwrite && (idx == esc_pkg::ESC_REG_12_15);

  esc_sel_reg #(
    .RST_VAL (esc_pkg::ESC_RST_MAP_0_3)
  ) u_map_0_3 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_en[0]),
    .wr_strb (pstrb),
    .wr_data (pwdata),
    .q       (q_0_3)
  );

  esc_sel_reg #(
    .RST_VAL (esc_pkg::ESC_RST_MAP_4_7)
  ) u_map_4_7 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_en[1]),
    .wr_strb (pstrb),
    .wr_data (pwdata),
    .q       (q_4_7)
  );

  esc_sel_reg #(
    .RST_VAL (esc_pkg::ESC_RST_MAP_12_15)
  ) u_map_12_15 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_en[2]),
    .wr_strb (pstrb),
    .wr_data (pwdata),
    .q       (q_12_15)
  );

  assign table_vec = esc_pkg::esc_event_table(events);

  // field i of each register drives the i-th channel of its group
  always_comb begin
    for (int i = 0; i < esc_pkg::ESC_FIELDS; i++) begin
      code_lo[i]  = q_0_3[i*esc_pkg::ESC_FIELD_STR +: esc_pkg::ESC_CODE_W];
      code_mid[i] = q_4_7[i*esc_pkg::ESC_FIELD_STR +: esc_pkg::ESC_CODE_W];
      code_hi[i]  = q_12_15[i*esc_pkg::ESC_FIELD_STR +: esc_pkg::ESC_CODE_W];
    end
  end

  genvar g;
  generate
    for (g = 0; g < esc_pkg::ESC_FIELDS; g++) begin : g_mux
      esc_event_mux u_lo (
        .code      (code_lo[g]),
        .table_vec (table_vec),
        .hit       (route[g])
      );
      esc_event_mux u_mid (
        .code      (code_mid[g]),
        .table_vec (table_vec),
        .hit       (route[g+4])
      );
      esc_event_mux u_hi (
        .code      (code_hi[g]),
        .table_vec (table_vec),
        .hit       (route[g+12])
      );
    end
  endgenerate

  // chaining channels never pass through a selector
  assign route[11:8] = chain;

  always_comb begin
    s_next        = s_reg;
    s_next.trig   = route;
    s_next.wr_seen = s_reg.wr_seen | wr_en;
    // read data captured in setup so it is a flop during the access cycle
    if (setup) begin
      s_next.slverr = (idx == esc_pkg::ESC_REG_NONE);
      case (idx)
        esc_pkg::ESC_REG_0_3:   s_next.prdata = pwrite ? 32'h00000000 : q_0_3;
        esc_pkg::ESC_REG_4_7:   s_next.prdata = pwrite ? 32'h00000000 : q_4_7;
        esc_pkg::ESC_REG_12_15: s_next.prdata = pwrite ? 32'h00000000 : q_12_15;
        default:                s_next.prdata = 32'h00000000;
      endcase
    end else if (access) begin
      s_next.prdata = s_reg.prdata;
    end else begin
      s_next.prdata = 32'h00000000;
      s_next.slverr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata          = s_reg.prdata;
  assign pslverr         = s_reg.slverr && access;
  assign channel_trigger = s_reg.trig;

  a_chain_pass: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 channel_trigger[11:8] == $past(chain))
    else $error("chain channel did not follow its completion input");

  a_hole_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && paddr == esc_pkg::ESC_ADDR_HOLE) |=> (access && pslverr))
    else $error("access to the empty slot was not flagged");

  a_map_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == esc_pkg::ESC_ADDR_MAP_12_15)
      |=> (prdata == q_12_15 && !pslverr))
    else $error("read of channels 12 to 15 returned wrong data");

  a_write_field: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == esc_pkg::ESC_ADDR_MAP_4_7 && pstrb[2])
      |=> (q_4_7[21:16] == $past(pwdata[21:16])))
    else $error("write to channel 6 field did not land");

  a_strb_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == esc_pkg::ESC_ADDR_MAP_0_3 && !pstrb[3])
      |=> $stable(q_0_3[29:24]))
    else $error("unstrobed field of channel 3 changed");

  a_resv_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((q_0_3 | q_4_7 | q_12_15) & esc_pkg::ESC_RESV_MASK) == 32'h00000000)
    else $error("reserved selector bits are not zero");

  a_reset_lo: assert property (
    @(posedge pclk) disable iff (!presetn)
    !s_reg.wr_seen[0] |-> q_0_3 == esc_pkg::ESC_RST_MAP_0_3)
    else $error("channels 0 to 3 lost their reset mapping");

  a_reset_mid: assert property (
    @(posedge pclk) disable iff (!presetn)
    !s_reg.wr_seen[1] |-> q_4_7 == esc_pkg::ESC_RST_MAP_4_7)
    else $error("channels 4 to 7 lost their reset mapping");

  a_reset_hi: assert property (
    @(posedge pclk) disable iff (!presetn)
    !s_reg.wr_seen[2] |-> q_12_15 == esc_pkg::ESC_RST_MAP_12_15)
    else $error("channels 12 to 15 lost their reset mapping");

  a_timer_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    (code_hi[3] == esc_pkg::ESC_CODE_TIMER0 && events.timer0_event)
      |=> channel_trigger[15])
    else $error("timer 0 event did not reach channel 15");

  a_serial_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    (code_lo[0] == esc_pkg::ESC_CODE_SER1_RX)
      |=> channel_trigger[0] == $past(events.serial1_receive_event))
    else $error("serial 1 receive routing to channel 0 is wrong");

  a_gpio2_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    (code_mid[0] == esc_pkg::ESC_CODE_GPIO2)
      |=> channel_trigger[4] == $past(events.gpio_pin2_event))
    else $error("gpio pin 2 routing to channel 4 is wrong");

  a_resv_code: assert property (
    @(posedge pclk) disable iff (!presetn)
    (code_hi[0] == esc_pkg::ESC_CODE_RESV_8 || code_hi[0] >= esc_pkg::ESC_CODE_TABLE_END)
      |=> !channel_trigger[12])
    else $error("reserved code produced a trigger on channel 12");

  a_trig_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    (events == '0 && chain == '0)
      |=> channel_trigger == 16'h0000)
    else $error("a trigger fired with every source idle");

  a_read_lo: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == esc_pkg::ESC_ADDR_MAP_0_3)
      |=> (prdata == q_0_3 && !pslverr))
    else $error("read of channels 0 to 3 returned wrong data");

  a_read_mid: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == esc_pkg::ESC_ADDR_MAP_4_7)
      |=> (prdata == q_4_7 && !pslverr))
    else $error("read of channels 4 to 7 returned wrong data");

  a_err_mapped: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && idx != esc_pkg::ESC_REG_NONE)
      |=> !pslverr)
    else $error("access to a mapped register was flagged");

  a_err_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    !access
      |-> !pslverr)
    else $error("error flag raised outside an access cycle");

  a_hole_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == esc_pkg::ESC_ADDR_HOLE)
      |=> ($stable(q_0_3) && $stable(q_4_7) && $stable(q_12_15)))
    else $error("write to the empty slot changed a selector");

  a_idle_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(access && pwrite)
      |=> ($stable(q_0_3) && $stable(q_4_7) && $stable(q_12_15)))
    else $error("selector changed without a write");

  a_write_lo: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == esc_pkg::ESC_ADDR_MAP_0_3 && pstrb[0])
      |=> (q_0_3[5:0] == $past(pwdata[5:0])))
    else $error("write to channel 0 field did not land");

  a_write_hi: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == esc_pkg::ESC_ADDR_MAP_12_15 && pstrb[3])
      |=> (q_12_15[29:24] == $past(pwdata[29:24])))
    else $error("write to channel 15 field did not land");

  a_strb_lo: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == esc_pkg::ESC_ADDR_MAP_0_3 && !pstrb[1])
      |=> $stable(q_0_3[13:8]))
    else $error("unstrobed field of channel 1 changed");

  a_host_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    (code_lo[1] == esc_pkg::ESC_CODE_HOST_DOORBELL)
      |=> channel_trigger[1] == $past(events.host_doorbell_event))
    else $error("doorbell routing to channel 1 is wrong");

  a_memif_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    (code_mid[3] == esc_pkg::ESC_CODE_MEMIF)
      |=> channel_trigger[7] == $past(events.memory_interface_event))
    else $error("memory interface routing to channel 7 is wrong");

  a_ser0_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    (code_mid[1] == esc_pkg::ESC_CODE_SER0_TX)
      |=> channel_trigger[5] == $past(events.serial0_transmit_event))
    else $error("serial 0 transmit routing to channel 5 is wrong");

  a_gpio4_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    (code_hi[2] == esc_pkg::ESC_CODE_GPIO4)
      |=> channel_trigger[14] == $past(events.gpio_pin4_event))
    else $error("gpio pin 4 routing to channel 14 is wrong");

  a_gpio7_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    (code_lo[3] == esc_pkg::ESC_CODE_GPIO7)
      |=> channel_trigger[3] == $past(events.gpio_pin7_event))
    else $error("gpio pin 7 routing to channel 3 is wrong");

  a_resv_lo: assert property (
    @(posedge pclk) disable iff (!presetn)
    (code_lo[2] == esc_pkg::ESC_CODE_RESV_8 || code_lo[2] >= esc_pkg::ESC_CODE_TABLE_END)
      |=> !channel_trigger[2])
    else $error("reserved code produced a trigger on channel 2");

  a_resv_mid: assert property (
    @(posedge pclk) disable iff (!presetn)
    (code_mid[3] == esc_pkg::ESC_CODE_RESV_8 || code_mid[3] >= esc_pkg::ESC_CODE_TABLE_END)
      |=> !channel_trigger[7])
    else $error("reserved code produced a trigger on channel 7");

endmodule

// ### esc_event_src.sv
// Purpose: far-side model of the peripheral event sources and chain completions
// Assumes: sources are synchronous to pclk and fire single-cycle pulses
// Notes:   lines return low after each pulse, as real sources idle low
`timescale 1ns/1ps
module esc_event_src (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // pulse request
  input  wire logic                 go,
  input  wire esc_pkg::esc_events_s ev_req,
  input  wire esc_pkg::esc_chain_s  ch_req,
  // toward the selector
  output esc_pkg::esc_events_s      events,
  output esc_pkg::esc_chain_s       chain
);
  // one-cycle pulses only; a held level would hide a missing trigger register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events <= '0;
      chain  <= '0;
    end else begin
      events <= go ? ev_req : '0;
      chain  <= go ? ch_req : '0;
    end
  end
endmodule

// ### esc_selector_bench.sv
// Purpose: self-checking bench of the event channel selector
// Assumes: APB slave answering on pready, triggers one cycle after the event
// Notes:   a shadow copy of the three registers drives the trigger expectations of channels 0 to 7 and 12 to 15 and the register reads after reset
`timescale 1ns/1ps
module esc_selector_bench;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, go;
  logic [31:0]          paddr, pwdata, prdata, rdata;
  logic [3:0]           pstrb;
  logic                 err;
  logic [15:0]          channel_trigger;
  esc_pkg::esc_events_s events, ev_req;
  esc_pkg::esc_chain_s  chain, ch_req;
  logic [31:0]          sh [3];
  logic [31:0]          addr [3];
  logic [5:0]           codes [13];
  logic [5:0]           resv [5];
  int                   err_total, checks_done, cycles;

  esc_selector dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events), .chain(chain),
    .channel_trigger(channel_trigger));
  esc_event_src src_u (.pclk(pclk), .presetn(presetn), .go(go), .ev_req(ev_req),
    .ch_req(ch_req), .events(events), .chain(chain));

  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      wrap_up;
    end
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // answer taken as it stands at the pready edge; only the bench timeout ends a stall
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int r, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, addr[r], d, s, rdata, err);
    for (int i = 0; i < 4; i++)
      if (s[i]) sh[r][i*8 +: 8] = {2'b00, d[i*8 +: 6]};
  endtask

  function automatic esc_pkg::esc_events_s ev_of(input logic [5:0] c);
    esc_pkg::esc_events_s v;
    v = '0;
    case (c)
      6'h00: v.host_doorbell_event = 1'b1;
      6'h01: v.timer0_event = 1'b1;
      6'h02: v.timer1_event = 1'b1;
      6'h03: v.memory_interface_event = 1'b1;
      6'h04: v.gpio_pin4_event = 1'b1;
      6'h05: v.gpio_pin5_event = 1'b1;
      6'h06: v.gpio_pin6_event = 1'b1;
      6'h07: v.gpio_pin7_event = 1'b1;
      6'h0A: v.gpio_pin2_event = 1'b1;
      6'h0C: v.serial0_transmit_event = 1'b1;
      6'h0D: v.serial0_receive_event = 1'b1;
      6'h0E: v.serial1_transmit_event = 1'b1;
      6'h0F: v.serial1_receive_event = 1'b1;
      default: v = '0;
    endcase
    return v;
  endfunction

  function automatic logic [15:0] trig_of(input esc_pkg::esc_events_s e,
                                          input esc_pkg::esc_chain_s c);
    logic [15:0] t;
    logic [3:0]  cv;
    logic [5:0]  k;
    cv = c;
    for (int ch = 0; ch < 16; ch++) begin
      if (ch >= 8 && ch <= 11) begin
        t[ch] = cv[ch-8];
      end else begin
        k = sh[(ch < 8) ? ch / 4 : 2][(ch % 4) * 8 +: 6];
        t[ch] = |(e & ev_of(k));
      end
    end
    return t;
  endfunction

  // pulse the sources and compare triggers one cycle after the selector samples
  task automatic pulse(input esc_pkg::esc_events_s e, input esc_pkg::esc_chain_s c);
    logic [15:0] exp;
    exp = trig_of(e, c);
    @(posedge pclk);
    go <= 1'b1;
    ev_req <= e;
    ch_req <= c;
    @(posedge pclk);
    go <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({16'h0000, channel_trigger}, {16'h0000, exp});
    // a one-cycle event must give a one-cycle trigger
    @(posedge pclk);
    chk({16'h0000, channel_trigger}, 32'h00000000);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    go = 1'b0;
    ev_req = '0;
    ch_req = '0;
    err_total = 0;
    checks_done = 0;
    cycles = 0;
    addr = '{32'h01A0FF00, 32'h01A0FF04, 32'h01A0FF0C};
    codes = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h0A,
              6'h0C, 6'h0D, 6'h0E, 6'h0F};
    resv = '{6'h08, 6'h09, 6'h0B, 6'h10, 6'h3F};
    sh = '{32'h03020100, 32'h07060504, 32'h0F0E0D0C};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // hole write must not land anywhere
    apb(1'b1, 32'h01A0FF08, 32'hFFFFFFFF, 4'hF, rdata, err);
    chk({31'h0, err}, 32'h00000001);
    apb(1'b0, 32'h01A0FF08, 32'h00000000, 4'hF, rdata, err);
    chk(rdata, 32'h00000000);
    chk({31'h0, err}, 32'h00000001);
    for (int r = 0; r < 3; r++) begin
      apb(1'b0, addr[r], 32'h00000000, 4'hF, rdata, err);
      chk(rdata, sh[r]);
      chk({31'h0, err}, 32'h00000000);
    end
    for (int k = 0; k < 13; k++)
      pulse(ev_of(codes[k]), '0);
    wr(0, 32'hFFFFFFFF, 4'hF);
    apb(1'b0, addr[0], 32'h00000000, 4'hF, rdata, err);
    chk(rdata, 32'h3F3F3F3F);
    wr(0, 32'h01010101, 4'h5);
    apb(1'b0, addr[0], 32'h00000000, 4'hF, rdata, err);
    chk(rdata, 32'h3F013F01);
    // one event fanned to every mappable channel, others kept silent
    for (int k = 0; k < 13; k++) begin
      for (int r = 0; r < 3; r++)
        wr(r, {4{2'b00, codes[k]}}, 4'hF);
      pulse(ev_of(codes[k]), '0);
      pulse(~ev_of(codes[k]), '0);
    end
    for (int k = 0; k < 5; k++) begin
      for (int r = 0; r < 3; r++)
        wr(r, {4{2'b00, resv[k]}}, 4'hF);
      pulse('1, '0);
    end
    pulse('0, 4'h5);
    pulse('1, 4'hA);
    // mid-run reset must bring back the default mapping
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({16'h0000, channel_trigger}, 32'h00000000);
    presetn <= 1'b1;
    sh = '{32'h03020100, 32'h07060504, 32'h0F0E0D0C};
    for (int r = 0; r < 3; r++) begin
      apb(1'b0, addr[r], 32'h00000000, 4'hF, rdata, err);
      chk(rdata, sh[r]);
    end
    pulse(ev_of(6'h0F), '0);
    wrap_up;
  end
endmodule
